// ---- rtl/ptt_top.sv ----
// What this block does
// - control bit 16 reads 1 if counter reached zero since last read
// - any read of the control/status register clears that flag
// - control bit 2 picks count clock: 0 reference, 1 core clock
// - control bit 1 set: pend tick exception on reaching zero
// - control bit 0 enables; writing 1 while stopped loads reload value and starts
// - the tick after reaching zero loads 24-bit reload field; bits 31-24 read zero
// - control at 0x010, reload at 0x014 above base 0xe000_e000
// - current value at 0x018, calibration at 0x01c, same base
// - any write to current value clears counter and zero flag
// - calibration reads fixed ten-ms count plus presence and exactness flags
//
// periodic tick timer: registers, counter, event and interrupt logic
// assumes an Avalon-MM master and a slow reference on REF_CLK_IN
`timescale 1ns/10ps
module ptt_top
   import ptt_pkg::*;
#(
   parameter int          COUNT_W     = COUNT_W_DEF,
   parameter logic [23:0] TEN_MS      = CALIB_TEN_MS_DEF,
   parameter logic        NO_REF      = 1'b0,
   parameter logic        CAL_INEXACT = 1'b0
)(
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic [31:0] AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   input  wire logic [3:0]  AVS_BYTEENABLE,
   output logic [31:0]      AVS_READDATA,
   output logic             AVS_WAITREQUEST,
   input  wire logic        REF_CLK_IN,
   output logic             TICK_PEND,
   output logic             IRQ
);

   generate
      if (COUNT_W < 2 || COUNT_W > 24) begin : g_bad_width
         $error("ptt_top counter width must lie in 2..24");
      end
   endgenerate

   // state
   ptt_ctrl_t          ctrl_ff;
   ptt_ctrl_t          nxt_ctrl;
   logic [COUNT_W-1:0] reload_ff;
   logic [COUNT_W-1:0] nxt_reload;
   logic [COUNT_W-1:0] count_ff;
   logic [COUNT_W-1:0] nxt_count;
   logic               flag_ff;
   logic               nxt_flag;
   logic [IRQ_W-1:0]   stat_ff;
   logic [IRQ_W-1:0]   nxt_stat;
   logic [IRQ_W-1:0]   mask_ff;
   logic [IRQ_W-1:0]   nxt_mask;
   logic               wait_ff;
   logic               nxt_wait;
   logic [31:0]        rdata_ff;
   logic               pend_ff;
   logic               irq_ff;

   // bus qualifiers
   logic        req;
   logic        take;
   logic        rd_acc;
   logic        wr_acc;
   logic        base_hit;
   logic        hit_ctrl;
   logic        hit_reload;
   logic        hit_cur;
   logic        hit_cal;
   logic        hit_stat;
   logic        hit_mask;
   logic [31:0] wmask;

   // datapath
   logic        ref_pulse;
   logic        tick;
   logic        start;
   logic        wr_cur;
   logic        rd_ctrl;
   logic        zero_evt;
   logic        reload_evt;
   logic        pend_evt;
   logic        cnt_is_one;
   logic        cnt_is_zero;
   logic [31:0] ctrl_word;
   logic [31:0] ctrl_wr;
   logic [31:0] reload_wr;
   logic [31:0] mask_wr;
   logic [31:0] cal_word;
   logic [31:0] rd_mux;

   ptt_ref_sync #(
      .STAGES (SYNC_STAGES_DEF)
   ) u_ref_sync (
      .clk    (CLK),
      .rst    (RST),
      .ref_in (REF_CLK_IN),
      .pulse  (ref_pulse)
   );

   // handshake: request seen, waitrequest drops next edge, done on the one after
   assign req      = AVS_READ | AVS_WRITE;
   assign take     = req & ~wait_ff;
   assign rd_acc   = AVS_READ & ~wait_ff;
   assign wr_acc   = AVS_WRITE & ~wait_ff;
   assign nxt_wait = take | ~req;

   assign base_hit   = AVS_ADDRESS[31:12] == PTT_BASE_ADDR[31:12];
   assign hit_ctrl   = base_hit & (AVS_ADDRESS[11:0] == OFS_CTRL);
   assign hit_reload = base_hit & (AVS_ADDRESS[11:0] == OFS_RELOAD);
   assign hit_cur    = base_hit & (AVS_ADDRESS[11:0] == OFS_CURRENT);
   assign hit_cal    = base_hit & (AVS_ADDRESS[11:0] == OFS_CALIB);
   assign hit_stat   = base_hit & (AVS_ADDRESS[11:0] == OFS_IRQ_STATUS);
   assign hit_mask   = base_hit & (AVS_ADDRESS[11:0] == OFS_IRQ_MASK);

   // byte lanes widen to a bit mask
   assign wmask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                   {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};

   // flag view includes an event in this cycle so a read never misses it
   assign ctrl_word = (32'(flag_ff | zero_evt) << CTRL_FLAG_BIT)
                    | (32'(ctrl_word_lo(ctrl_ff)));
   assign cal_word  = (32'(NO_REF) << CALIB_NO_REF_BIT)
                    | (32'(CAL_INEXACT) << CALIB_INEXACT_BIT)
                    | 32'(TEN_MS);

   function automatic logic [2:0] ctrl_word_lo(input ptt_ctrl_t c);
      ctrl_word_lo = {c.clk_sel, c.tick_en, c.run};
   endfunction : ctrl_word_lo

   // upper bits above the count read as zero
   assign rd_mux = hit_ctrl   ? ctrl_word :
                   hit_reload ? 32'(reload_ff) :
                   hit_cur    ? 32'(count_ff) :
                   hit_cal    ? cal_word :
                   hit_stat   ? 32'(stat_ff) :
                   hit_mask   ? 32'(mask_ff) : 32'h0000_0000;

   // merged write values keep bytes whose lane is off
   // control merge skips the flag view, which would loop back through start
   assign ctrl_wr   = (32'(ctrl_word_lo(ctrl_ff)) & ~wmask) | (AVS_WRITEDATA & wmask);
   assign reload_wr = (32'(reload_ff) & ~wmask) | (AVS_WRITEDATA & wmask);
   assign mask_wr   = (32'(mask_ff) & ~wmask) | (AVS_WRITEDATA & wmask);

   // register writes
   assign nxt_ctrl   = (wr_acc & hit_ctrl) ? ptt_ctrl_t'{clk_sel: ctrl_wr[CTRL_CLKSEL_BIT],
                                                      tick_en: ctrl_wr[CTRL_TICKEN_BIT],
                                                      run:     ctrl_wr[CTRL_RUN_BIT]}
                                          : ctrl_ff;
   assign nxt_reload = (wr_acc & hit_reload) ? reload_wr[COUNT_W-1:0] : reload_ff;
   assign nxt_mask   = (wr_acc & hit_mask) ? mask_wr[IRQ_W-1:0] : mask_ff;

   assign tick = ctrl_ff.clk_sel | ref_pulse;

   // enable rising from a write loads and starts
   assign start   = wr_acc & hit_ctrl & ctrl_wr[CTRL_RUN_BIT] & ~ctrl_ff.run;
   assign wr_cur  = wr_acc & hit_cur;
   assign rd_ctrl = rd_acc & hit_ctrl;

   assign cnt_is_one  = count_ff == COUNT_W'(1);
   assign cnt_is_zero = count_ff == '0;

   // one-to-zero on a tick is the event
   assign zero_evt   = ctrl_ff.run & tick & cnt_is_one & ~wr_cur & ~start;
   assign reload_evt = ctrl_ff.run & tick & cnt_is_zero & ~wr_cur & ~start;
   assign pend_evt   = zero_evt & ctrl_ff.tick_en;

   // counter next value; clear by write has top priority
   always_comb begin
      nxt_count = count_ff;
      if (wr_cur) begin
         nxt_count = '0;
      end else if (start) begin
         nxt_count = reload_ff;
      end else if (reload_evt) begin
         nxt_count = reload_ff;
      end else if (ctrl_ff.run & tick) begin
         nxt_count = count_ff - COUNT_W'(1);
      end
   end

   // event sets flag; set wins over clear
   assign nxt_flag = zero_evt | (flag_ff & ~rd_ctrl & ~wr_cur);

   // sticky status, write one to clear, new event wins
   assign nxt_stat = (pend_evt ? IRQ_W'(1) << IRQ_TICK_BIT : '0)
                   | (stat_ff & ~((wr_acc & hit_stat) ? AVS_WRITEDATA[IRQ_W-1:0] : '0));

   // control and configuration registers
   always_ff @(posedge CLK) begin
      if (RST) begin
         ctrl_ff   <= CTRL_RST;
         reload_ff <= '0;
         mask_ff   <= IRQ_RST;
      end else begin
         ctrl_ff   <= nxt_ctrl;
         reload_ff <= nxt_reload;
         mask_ff   <= nxt_mask;
      end
   end

   // counter, flag and interrupt state
   always_ff @(posedge CLK) begin
      if (RST) begin
         count_ff <= '0;
         flag_ff  <= 1'b0;
         stat_ff  <= IRQ_RST;
         pend_ff  <= 1'b0;
         irq_ff   <= 1'b0;
      end else begin
         count_ff <= nxt_count;
         flag_ff  <= nxt_flag;
         stat_ff  <= nxt_stat;
         pend_ff  <= pend_evt;
         irq_ff   <= |(stat_ff & mask_ff);
      end
   end

   // bus answer; read data captured when waitrequest drops, held through
   always_ff @(posedge CLK) begin
      if (RST) begin
         wait_ff  <= 1'b1;
         rdata_ff <= 32'h0000_0000;
      end else begin
         wait_ff <= nxt_wait;
         if (AVS_READ & wait_ff) begin
            rdata_ff <= rd_mux;
         end
      end
   end

   assign AVS_READDATA    = rdata_ff;
   assign AVS_WAITREQUEST = wait_ff;
   assign TICK_PEND       = pend_ff;
   assign IRQ             = irq_ff;

   // checks next to the logic they guard
   a_flag_on_zero: assert property (@(posedge CLK) disable iff (RST)
      zero_evt |=> flag_ff ##1 (flag_ff || $past(rd_ctrl) || $past(wr_cur)))
      else $error("zero event did not set the flag");

   a_flag_read_clr: assert property (@(posedge CLK) disable iff (RST)
      (rd_ctrl && !zero_evt) |=> !flag_ff)
      else $error("control read left the flag set");

   a_ref_hold: assert property (@(posedge CLK) disable iff (RST)
      (!ctrl_ff.clk_sel && !ref_pulse && !start && !wr_cur) |=> $stable(count_ff))
      else $error("counter moved without a reference tick");

   a_pend_gate: assert property (@(posedge CLK) disable iff (RST)
      zero_evt |=> (TICK_PEND == $past(ctrl_ff.tick_en)))
      else $error("tick pend disagrees with its enable");

   a_start_load: assert property (@(posedge CLK) disable iff (RST)
      start |=> (count_ff == $past(reload_ff)) && ctrl_ff.run)
      else $error("enable did not load the reload value");

   a_zero_reload: assert property (@(posedge CLK) disable iff (RST)
      reload_evt |=> count_ff == $past(reload_ff))
      else $error("counter did not reload at zero");

   a_ctrl_decode: assert property (@(posedge CLK) disable iff (RST)
      (AVS_READ && wait_ff && hit_ctrl) |=>
         AVS_READDATA[2:0] == {ctrl_ff.clk_sel, ctrl_ff.tick_en, ctrl_ff.run})
      else $error("control read returned wrong fields");

   a_cur_decode: assert property (@(posedge CLK) disable iff (RST)
      (AVS_READ && wait_ff && hit_cur) |=> AVS_READDATA == 32'($past(count_ff)))
      else $error("current value read returned wrong data");

   a_cur_wr_clr: assert property (@(posedge CLK) disable iff (RST)
      wr_cur |=> (count_ff == '0) && !flag_ff)
      else $error("current value write did not clear");

   a_cal_value: assert property (@(posedge CLK) disable iff (RST)
      (AVS_READ && wait_ff && hit_cal) |=>
         AVS_READDATA[23:0] == TEN_MS && AVS_READDATA[29:24] == 6'h00)
      else $error("calibration read returned wrong value");

   a_dec_step: assert property (@(posedge CLK) disable iff (RST)
      (ctrl_ff.run && tick && !cnt_is_zero && !start && !wr_cur) |=>
         count_ff == $past(count_ff) - COUNT_W'(1))
      else $error("counter did not step down by one");

   a_bus_answer: assert property (@(posedge CLK) disable iff (RST)
      (req && wait_ff) |=> !AVS_WAITREQUEST)
      else $error("waitrequest did not drop one cycle after request");

endmodule : ptt_top

// ---- rtl/ptt_pkg.sv ----
// constants and types shared by the periodic tick timer files
// assumes a 32-bit byte-addressed register bus behind a fixed base address
package ptt_pkg;

   // base of the system control block and register byte offsets
   localparam logic [31:0] PTT_BASE_ADDR  = 32'he000_e000;
   localparam logic [11:0] OFS_CTRL       = 12'h010;
   localparam logic [11:0] OFS_RELOAD     = 12'h014;
   localparam logic [11:0] OFS_CURRENT    = 12'h018;
   localparam logic [11:0] OFS_CALIB      = 12'h01c;
   localparam logic [11:0] OFS_IRQ_STATUS = 12'h020;
   localparam logic [11:0] OFS_IRQ_MASK   = 12'h024;

   // control/status field positions
   localparam int CTRL_RUN_BIT     = 0;
   localparam int CTRL_TICKEN_BIT  = 1;
   localparam int CTRL_CLKSEL_BIT  = 2;
   localparam int CTRL_FLAG_BIT    = 16;

   // calibration field positions and default contents
   localparam int          CALIB_NO_REF_BIT  = 31;
   localparam int          CALIB_INEXACT_BIT = 30;
   localparam int          COUNT_W_DEF       = 24;
   localparam logic [23:0] CALIB_TEN_MS_DEF  = 24'h0009c4;

   // interrupt status layout: one event bit
   localparam int          IRQ_W        = 1;
   localparam int          IRQ_TICK_BIT = 0;
   localparam logic [0:0]  IRQ_RST      = 1'h0;

   // control fields carried together
   typedef struct packed {
      logic clk_sel;   // 1 core clock, 0 external reference
      logic tick_en;   // pend exception on zero
      logic run;       // counter enabled
   } ptt_ctrl_t;

   localparam ptt_ctrl_t CTRL_RST = '{clk_sel: 1'b0, tick_en: 1'b0, run: 1'b0};

   // reference synchroniser depth
   localparam int SYNC_STAGES_DEF = 2;

endpackage : ptt_pkg

// ---- rtl/ptt_ref_sync.sv ----
// synchroniser and rising-edge detector for the external reference
// assumes the reference is much slower than the core clock
`timescale 1ns/10ps
module ptt_ref_sync
   import ptt_pkg::*;
#(
   parameter int STAGES = SYNC_STAGES_DEF
)(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic ref_in,
   output logic      pulse
);

   generate
      if (STAGES < 2) begin : g_bad_stages
         $error("ptt_ref_sync needs at least two stages");
      end
   endgenerate

   logic [STAGES-1:0] sync_ff;
   logic [STAGES-1:0] nxt_sync;
   logic              prev_ff;
   logic              pulse_ff;
   logic              nxt_pulse;

   // only the last stage feeds the edge detector
   assign nxt_sync  = {sync_ff[STAGES-2:0], ref_in};
   assign nxt_pulse = sync_ff[STAGES-1] & ~prev_ff;
   assign pulse     = pulse_ff;

   always_ff @(posedge clk) begin
      if (rst) begin
         sync_ff  <= '0;
         prev_ff  <= 1'b0;
         pulse_ff <= 1'b0;
      end else begin
         sync_ff  <= nxt_sync;
         prev_ff  <= sync_ff[STAGES-1];
         pulse_ff <= nxt_pulse;
      end
   end

   a_pulse_single: assert property (@(posedge clk) disable iff (rst)
      pulse_ff |=> !pulse_ff)
      else $error("reference enable lasted more than one cycle");

endmodule : ptt_ref_sync

// ---- verif/tb_periodic_tick_timer.sv ----
// self-checking bench for the periodic tick timer top level
// assumes ptt_top answers every Avalon-MM access after one wait cycle
`timescale 1ns/10ps
module tb_periodic_tick_timer;
   import ptt_pkg::*;

   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [31:0] addr = '0;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wdata = '0;
   logic [3:0]  be = 4'hf;
   logic [31:0] rdata;
   logic        waitreq;
   logic        ref_in = 1'b0;
   logic        ref_on = 1'b0;
   logic [2:0]  ref_cnt = 3'h0;
   logic        tick_pend;
   logic        irq;
   int          n_fail = 0;
   int          comparisons = 0;

   ptt_top dut_u (.CLK(clk), .RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
      .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
      .AVS_WAITREQUEST(waitreq), .REF_CLK_IN(ref_in), .TICK_PEND(tick_pend), .IRQ(irq));

   // 100 MHz core clock
   always #5 clk = ~clk;

   // slow reference, one rising edge every 16 core cycles while enabled
   always @(posedge clk) begin
      if (ref_on) begin
         ref_cnt <= ref_cnt + 3'h1;
         if (ref_cnt == 3'h7) ref_in <= ~ref_in;
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   // one bus access; request held until waitrequest is sampled low
   task automatic bus_xfer(input logic is_wr, input logic [31:0] a, input logic [31:0] d,
                           input logic [3:0] b, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      addr  <= a;
      rd    <= ~is_wr;
      wr    <= is_wr;
      wdata <= d;
      be    <= b;
      do begin
         @(posedge clk);
         n++;
      end while (waitreq !== 1'b0 && n < 50);
      if (n >= 50) check(32'h0, 32'h1, "bus answer missing");
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus_xfer

   task automatic wr_reg(input logic [11:0] ofs, input logic [31:0] d);
      logic [31:0] q;
      bus_xfer(1'b1, {PTT_BASE_ADDR[31:12], ofs}, d, 4'hf, q);
   endtask : wr_reg

   task automatic rd_chk(input logic [11:0] ofs, input logic [31:0] exp, input string what);
      logic [31:0] q;
      bus_xfer(1'b0, {PTT_BASE_ADDR[31:12], ofs}, 32'h0, 4'hf, q);
      check(q, exp, what);
   endtask : rd_chk

   // cycles until the next sampled tick pulse, bounded
   task automatic tick_gap(output int gap);
      gap = 0;
      do begin
         @(posedge clk);
         gap++;
      end while (tick_pend !== 1'b1 && gap < 2000);
   endtask : tick_gap

   task automatic t_reset_map;
      check({29'h0, waitreq, tick_pend, irq}, 32'h4, "outputs after reset");
      check(rdata, 32'h0, "read data after reset");
      rd_chk(OFS_CTRL, 32'h0, "ctrl reset");
      rd_chk(OFS_RELOAD, 32'h0, "reload reset");
      rd_chk(OFS_CURRENT, 32'h0, "current reset");
      rd_chk(OFS_CALIB, 32'h0000_09c4, "calibration");
      rd_chk(12'h028, 32'h0, "unmapped read");
   endtask : t_reset_map

   // reload width, byte lanes, refused writes
   task automatic t_reload;
      logic [31:0] q;
      wr_reg(OFS_RELOAD, 32'hffff_ffff);
      rd_chk(OFS_RELOAD, 32'h00ff_ffff, "reload upper bits");
      bus_xfer(1'b1, {PTT_BASE_ADDR[31:12], OFS_RELOAD}, 32'h0000_0012, 4'h1, q);
      rd_chk(OFS_RELOAD, 32'h00ff_ff12, "reload byte lane");
      wr_reg(12'h028, 32'h0);
      bus_xfer(1'b1, 32'h0000_0014, 32'h0, 4'hf, q);
      wr_reg(OFS_CALIB, 32'h0);
      rd_chk(OFS_RELOAD, 32'h00ff_ff12, "foreign write hit reload");
      rd_chk(OFS_CALIB, 32'h0000_09c4, "calibration written");
   endtask : t_reload

   // start loads reload, stop freezes count
   task automatic t_run_stop;
      logic [31:0] a;
      logic [31:0] b;
      wr_reg(OFS_RELOAD, 32'h20);
      wr_reg(OFS_CTRL, 32'h5);
      wr_reg(OFS_CTRL, 32'h4);
      bus_xfer(1'b0, {PTT_BASE_ADDR[31:12], OFS_CURRENT}, 32'h0, 4'hf, a);
      check({31'h0, a < 32'h20 && a > 32'h18}, 32'h1, "count after short run");
      repeat (10) @(posedge clk);
      bus_xfer(1'b0, {PTT_BASE_ADDR[31:12], OFS_CURRENT}, 32'h0, 4'hf, b);
      check(b, a, "count not frozen");
      rd_chk(OFS_CTRL, 32'h4, "flag without zero");
   endtask : t_run_stop

   // core clock ticks and sticky flag
   task automatic t_core_ticks;
      int gap;
      logic seen;
      seen = 1'b0;
      wr_reg(OFS_RELOAD, 32'h5);
      wr_reg(OFS_CTRL, 32'h5);
      repeat (20) begin
         @(posedge clk);
         if (tick_pend !== 1'b0) seen = 1'b1;
      end
      check({31'h0, seen}, 32'h0, "pend with exception off");
      wr_reg(OFS_CTRL, 32'h7);
      tick_gap(gap);
      tick_gap(gap);
      check(32'(gap), 32'h6, "core tick period");
      wr_reg(OFS_CTRL, 32'h4);
      rd_chk(OFS_CTRL, 32'h0001_0004, "flag after zero");
      rd_chk(OFS_CTRL, 32'h0000_0004, "flag after read");
   endtask : t_core_ticks

   // current write clears count and flag
   task automatic t_current_clear;
      wr_reg(OFS_CTRL, 32'h7);
      repeat (20) @(posedge clk);
      wr_reg(OFS_CTRL, 32'h4);
      wr_reg(OFS_CURRENT, 32'hdead_beef);
      rd_chk(OFS_CURRENT, 32'h0, "current after write");
      rd_chk(OFS_CTRL, 32'h4, "flag after current write");
   endtask : t_current_clear

   // tick events reach status, mask and irq
   task automatic t_irq;
      rd_chk(OFS_IRQ_STATUS, 32'h1, "status sticky");
      check({31'h0, irq}, 32'h0, "irq while masked");
      wr_reg(OFS_IRQ_MASK, 32'h1);
      repeat (3) @(posedge clk);
      check({31'h0, irq}, 32'h1, "irq unmasked");
      rd_chk(OFS_IRQ_MASK, 32'h1, "mask readback");
      wr_reg(OFS_IRQ_STATUS, 32'h1);
      repeat (3) @(posedge clk);
      check({31'h0, irq}, 32'h0, "irq after clear");
      rd_chk(OFS_IRQ_STATUS, 32'h0, "status after clear");
   endtask : t_irq

   // reference clock as one-cycle count enable
   task automatic t_ref_ticks;
      int gap;
      logic [31:0] a;
      logic [31:0] b;
      wr_reg(OFS_RELOAD, 32'h3);
      ref_on <= 1'b1;
      wr_reg(OFS_CTRL, 32'h3);
      tick_gap(gap);
      tick_gap(gap);
      check(32'(gap), 32'h40, "reference tick period");
      ref_on <= 1'b0;
      bus_xfer(1'b0, {PTT_BASE_ADDR[31:12], OFS_CURRENT}, 32'h0, 4'hf, a);
      repeat (10) @(posedge clk);
      bus_xfer(1'b0, {PTT_BASE_ADDR[31:12], OFS_CURRENT}, 32'h0, 4'hf, b);
      check(b, a, "count moved without reference");
      wr_reg(OFS_CTRL, 32'h0);
   endtask : t_ref_ticks

   task automatic give_verdict;
      $display("mismatches %0d comparisons %0d", n_fail, comparisons);
      if (n_fail == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : give_verdict

   // main sequence
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset_map();
      t_reload();
      t_run_stop();
      t_core_ticks();
      t_current_clear();
      t_irq();
      t_ref_ticks();
      give_verdict();
   end

   // watchdog: whole run needs well under 2000 cycles
   initial begin
      #100000;
      n_fail++;
      give_verdict();
   end

endmodule : tb_periodic_tick_timer
